// ---- hdl/ger_pkg.sv ----
/*
 * Package for the pin and edge-event register block: register offsets,
 * field positions, reset values, serial frame layout and the state record.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
`default_nettype none
package ger_pkg;
	localparam int unsigned NUM_PINS   = 10;
	localparam int unsigned REG_W      = 16;
	localparam int unsigned ADDR_W     = 4;
	localparam int unsigned CNT_W      = 4;

	// Register offsets (word index within the frame address field).
	localparam logic [3:0] OFS_PIN_LEVEL = 4'h0;
	localparam logic [3:0] OFS_PIN_DIR   = 4'h1;
	localparam logic [3:0] OFS_RISE_EN   = 4'h2;
	localparam logic [3:0] OFS_FALL_EN   = 4'h3;
	localparam logic [3:0] OFS_FLAG_CS   = 4'h4;

	// Field positions.
	localparam int unsigned BIT_SER_DRIVE_LOW = 15;
	localparam int unsigned BIT_CONV_READY    = 11;
	localparam int unsigned BIT_TOUCH_PX      = 12;
	localparam int unsigned BIT_TOUCH_MX      = 13;
	localparam int unsigned BIT_TEL_CLIP      = 14;
	localparam int unsigned BIT_AUD_CLIP      = 15;

	// Implemented bits of the event registers: bits 0 to 9 and 11 to 15.
	localparam logic [15:0] EVENT_MASK = 16'hFBFF;
	localparam logic [15:0] DIR_MASK   = 16'h83FF;

	// Reset values.
	localparam logic [15:0] RST_REG = 16'h0000;

	// Serial frame: control word, write word, then the read word.
	localparam int unsigned CTRL_WRITE_BIT = 15;
	localparam int unsigned CTRL_ADDR_LSB  = 11;
	localparam logic [3:0]  WORD_LAST      = 4'hF;

	typedef enum logic [1:0] {
		GER_IDLE,
		GER_CTRL,
		GER_WDATA,
		GER_RDATA
	} ger_frame_t;

	// Synchroniser stages for all inputs from outside the clock domain.
	typedef struct packed {
		logic                sck;
		logic                sync;
		logic                din;
		logic [REG_W-1:0]    src;
	} ger_samp_t;

	typedef struct packed {
		ger_samp_t           s1;
		ger_samp_t           s2;
		logic                sck3;
		logic [REG_W-1:0]    src3;
		ger_frame_t          frame;
		logic [CNT_W-1:0]    cnt;
		logic [REG_W-1:0]    ctrl_sh;
		logic [REG_W-1:0]    wdata_sh;
		logic [REG_W-1:0]    rdata_sh;
		logic                sdo;
		logic                sdo_oe;
		logic [NUM_PINS-1:0] pin_out;
		logic [REG_W-1:0]    dir;
		logic [REG_W-1:0]    rise_en;
		logic [REG_W-1:0]    fall_en;
		logic [REG_W-1:0]    clr_last;
		logic [REG_W-1:0]    flags;
	} ger_state_t;
endpackage
`default_nettype wire

// ---- hdl/ger_regs.sv ----
/*
 * Pin data, direction, edge-event enable and event flag registers reached
 * over the four-wire serial interface bus.
 * A frame is 48 bus clock falls: a control word with the write flag and
 * the address, a write word applied at the last fall of the second word,
 * and a read word driven on the rising edges of the third word, MSB first.
 * The read word holds the register value from before that frame's write.
 * The event flags have no interrupt pin of their own; software polls them.
 * Assumes the serial bus clock runs well below a quarter of sys_clk_i and
 * that all pins and event sources are asynchronous to sys_clk_i.
 * Assumes ser_sync_i and ser_din_i are steady around each bus clock fall,
 * and that the controller waits for all 48 falls before the next frame.
 */
`default_nettype none
module ger_regs
	import ger_pkg::*;
(
	input  wire logic                sys_clk_i,
	input  wire logic                rst_b_i,
	input  wire logic                ser_clk_i,
	input  wire logic                ser_sync_i,
	input  wire logic                ser_din_i,
	output logic                     serial_data_output_o,
	output logic                     serial_data_output_oe_o,
	input  wire logic [NUM_PINS-1:0] pin_i,
	output logic      [NUM_PINS-1:0] pin_o,
	output logic      [NUM_PINS-1:0] pin_oe_o,
	input  wire logic                conv_ready_i,
	input  wire logic                touch_plus_x_line_i,
	input  wire logic                touch_minus_x_line_i,
	input  wire logic                tel_clip_i,
	input  wire logic                aud_clip_i
);
	ger_state_t       st_q;
	ger_state_t       st_d;
	ger_samp_t        raw;
	logic             sck_fall;
	logic             sck_rise;
	logic [REG_W-1:0] rise_ev;
	logic [REG_W-1:0] fall_ev;
	logic [REG_W-1:0] set_ev;
	logic [REG_W-1:0] clr_ev;
	logic [REG_W-1:0] rdata;
	logic [ADDR_W-1:0] addr;
	logic             wr_en;
	logic [REG_W-1:0] src_now;
	logic [REG_W-1:0] src_old;
	logic [REG_W-1:0] wdata_full;
	logic             word_end;
	logic             wr_strobe;
	logic             wr_pin;
	logic             wr_dir;
	logic             wr_rise;
	logic             wr_fall;
	logic             wr_flag;
	logic [NUM_PINS-1:0] pin_set;
	logic             conv_set;
	logic             tpx_set;
	logic             tmx_set;
	logic             tel_set;
	logic             aud_set;

	assign raw.sck  = ser_clk_i;
	assign raw.sync = ser_sync_i;
	assign raw.din  = ser_din_i;
	assign raw.src[NUM_PINS-1:0]   = pin_i;
	assign raw.src[10]             = 1'b0;
	assign raw.src[BIT_CONV_READY] = conv_ready_i;
	assign raw.src[BIT_TOUCH_PX]   = touch_plus_x_line_i;
	assign raw.src[BIT_TOUCH_MX]   = touch_minus_x_line_i;
	assign raw.src[BIT_TEL_CLIP]   = tel_clip_i;
	assign raw.src[BIT_AUD_CLIP]   = aud_clip_i;

	always_comb begin
		st_d = st_q;
		// Two stages, then a third copy for edge finding.
		st_d.s1   = raw;
		st_d.s2   = st_q.s1;
		st_d.sck3 = st_q.s2.sck;
		st_d.src3 = st_q.s2.src;
		sck_fall  = st_q.sck3 & ~st_q.s2.sck;
		sck_rise  = ~st_q.sck3 & st_q.s2.sck;

		// Edge events gated by the enables.
		src_now = st_q.s2.src;
		src_old = st_q.src3;
		rise_ev = src_now & ~src_old & st_q.rise_en;
		fall_ev = ~src_now & src_old & st_q.fall_en;
		set_ev  = (rise_ev | fall_ev) & EVENT_MASK;

		// Set requests per source group.
		pin_set  = set_ev[NUM_PINS-1:0];
		conv_set = set_ev[BIT_CONV_READY];
		tpx_set  = set_ev[BIT_TOUCH_PX];
		tmx_set  = set_ev[BIT_TOUCH_MX];
		tel_set  = set_ev[BIT_TEL_CLIP];
		aud_set  = set_ev[BIT_AUD_CLIP];

		// Control word decoding.
		addr  = st_q.ctrl_sh[CTRL_ADDR_LSB +: ADDR_W];
		wr_en = st_q.ctrl_sh[CTRL_WRITE_BIT];

		// Write strobe at the last fall of the write word.
		wdata_full = {st_q.wdata_sh[REG_W-2:0], st_q.s2.din};
		word_end   = sck_fall && (st_q.cnt == WORD_LAST);
		wr_strobe  = (st_q.frame == GER_WDATA) && word_end && wr_en;
		wr_pin     = wr_strobe && (addr == OFS_PIN_LEVEL);
		wr_dir     = wr_strobe && (addr == OFS_PIN_DIR);
		wr_rise    = wr_strobe && (addr == OFS_RISE_EN);
		wr_fall    = wr_strobe && (addr == OFS_FALL_EN);
		wr_flag    = wr_strobe && (addr == OFS_FLAG_CS);

		// Read multiplexer.
		if (addr == OFS_PIN_LEVEL) begin
			rdata = {6'h00, st_q.s2.src[NUM_PINS-1:0]};
		end else if (addr == OFS_PIN_DIR) begin
			rdata                    = 16'h0000;
			rdata[NUM_PINS-1:0]      = st_q.dir[NUM_PINS-1:0];
			rdata[BIT_SER_DRIVE_LOW] = st_q.dir[BIT_SER_DRIVE_LOW];
		end else if (addr == OFS_RISE_EN) begin
			rdata = st_q.rise_en;
		end else if (addr == OFS_FALL_EN) begin
			rdata = st_q.fall_en;
		end else if (addr == OFS_FLAG_CS) begin
			rdata                 = 16'h0000;
			rdata[NUM_PINS-1:0]   = st_q.flags[NUM_PINS-1:0];
			rdata[BIT_CONV_READY] = st_q.flags[BIT_CONV_READY];
			rdata[BIT_TOUCH_PX]   = st_q.flags[BIT_TOUCH_PX];
			rdata[BIT_TOUCH_MX]   = st_q.flags[BIT_TOUCH_MX];
			rdata[BIT_TEL_CLIP]   = st_q.flags[BIT_TEL_CLIP];
			rdata[BIT_AUD_CLIP]   = st_q.flags[BIT_AUD_CLIP];
		end else begin
			rdata = 16'h0000;
		end

		clr_ev = 16'h0000;

		// Serial frame sequencing on the sampled bus clock.
		case (st_q.frame)
			GER_IDLE: begin
				st_d.sdo_oe = 1'b0;
				if (sck_fall && st_q.s2.sync) begin
					st_d.frame   = GER_CTRL;
					st_d.ctrl_sh = {st_q.ctrl_sh[REG_W-2:0], st_q.s2.din};
					st_d.cnt     = 4'h1;
				end
			end
			GER_CTRL: begin
				if (sck_fall) begin
					st_d.ctrl_sh = {st_q.ctrl_sh[REG_W-2:0], st_q.s2.din};
					st_d.cnt     = st_q.cnt + 4'h1;
					if (st_q.cnt == WORD_LAST) begin
						st_d.frame  = GER_WDATA;
						st_d.sdo    = 1'b0;
						st_d.sdo_oe = st_q.dir[BIT_SER_DRIVE_LOW];
					end
				end
			end
			GER_WDATA: begin
				if (sck_fall) begin
					st_d.wdata_sh = {st_q.wdata_sh[REG_W-2:0], st_q.s2.din};
					st_d.cnt      = st_q.cnt + 4'h1;
					if (st_q.cnt == WORD_LAST) begin
						st_d.frame    = GER_RDATA;
						st_d.sdo_oe   = 1'b0;
						st_d.rdata_sh = rdata;
					end
				end
			end
			GER_RDATA: begin
				if (sck_rise) begin
					st_d.sdo      = st_q.rdata_sh[REG_W-1];
					st_d.sdo_oe   = 1'b1;
					st_d.rdata_sh = {st_q.rdata_sh[REG_W-2:0], 1'b0};
				end
				if (sck_fall) begin
					st_d.cnt = st_q.cnt + 4'h1;
					if (st_q.cnt == WORD_LAST) begin
						st_d.frame  = GER_IDLE;
						st_d.sdo_oe = 1'b0;
					end
				end
			end
			default: begin
				st_d.frame = GER_IDLE;
			end
		endcase

		// Register writes at the end of the write word.
		if (wr_pin) begin
			st_d.pin_out = wdata_full[NUM_PINS-1:0];
		end
		if (wr_dir) begin
			st_d.dir = wdata_full & DIR_MASK;
		end
		if (wr_rise) begin
			st_d.rise_en = wdata_full & EVENT_MASK;
		end
		if (wr_fall) begin
			st_d.fall_en = wdata_full & EVENT_MASK;
		end
		if (wr_flag) begin
			// Only a zero-to-one change clears.
			clr_ev        = wdata_full & ~st_q.clr_last & EVENT_MASK;
			st_d.clr_last = wdata_full & EVENT_MASK;
		end

		// Set wins over a clear in the same cycle.
		st_d.flags[NUM_PINS-1:0] = (st_q.flags[NUM_PINS-1:0]
			& ~clr_ev[NUM_PINS-1:0]) | pin_set;
		st_d.flags[10] = 1'b0;
		st_d.flags[BIT_CONV_READY] = (st_q.flags[BIT_CONV_READY]
			& ~clr_ev[BIT_CONV_READY]) | conv_set;
		st_d.flags[BIT_TOUCH_PX] = (st_q.flags[BIT_TOUCH_PX]
			& ~clr_ev[BIT_TOUCH_PX]) | tpx_set;
		st_d.flags[BIT_TOUCH_MX] = (st_q.flags[BIT_TOUCH_MX]
			& ~clr_ev[BIT_TOUCH_MX]) | tmx_set;
		st_d.flags[BIT_TEL_CLIP] = (st_q.flags[BIT_TEL_CLIP]
			& ~clr_ev[BIT_TEL_CLIP]) | tel_set;
		st_d.flags[BIT_AUD_CLIP] = (st_q.flags[BIT_AUD_CLIP]
			& ~clr_ev[BIT_AUD_CLIP]) | aud_set;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			st_q.s1       <= '0;
			st_q.s2       <= '0;
			st_q.sck3     <= 1'b0;
			st_q.src3     <= '0;
			st_q.frame    <= GER_IDLE;
			st_q.cnt      <= '0;
			st_q.ctrl_sh  <= RST_REG;
			st_q.wdata_sh <= RST_REG;
			st_q.rdata_sh <= RST_REG;
			st_q.sdo      <= 1'b0;
			st_q.sdo_oe   <= 1'b0;
			st_q.pin_out  <= '0;
			st_q.dir      <= RST_REG;
			st_q.rise_en  <= RST_REG;
			st_q.fall_en  <= RST_REG;
			st_q.clr_last <= RST_REG;
			st_q.flags    <= RST_REG;
		end else begin
			st_q <= st_d;
		end
	end

	assign pin_o                   = st_q.pin_out;
	assign pin_oe_o                = st_q.dir[NUM_PINS-1:0];
	assign serial_data_output_o    = st_q.sdo;
	assign serial_data_output_oe_o = st_q.sdo_oe;
endmodule
`default_nettype wire

// ---- verif/ger_regs_chk.sv ----
/* Port checker for the pin and edge-event register block.
 * Assumes one clock domain with a synchronous active-low reset. */
`default_nettype none
module ger_regs_chk
	import ger_pkg::*;
(
	input wire logic                sys_clk_i,
	input wire logic                rst_b_i,
	input wire logic                ser_clk_i,
	input wire logic                serial_data_output_o,
	input wire logic                serial_data_output_oe_o,
	input wire logic [NUM_PINS-1:0] pin_o,
	input wire logic [NUM_PINS-1:0] pin_oe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_b_i);
	sequence s_low;
		!ser_clk_i && !$past(ser_clk_i);
	endsequence
	sequence s_word2;
		!serial_data_output_o [*8];
	endsequence
	AST_RST_PINS: assert property ($rose(rst_b_i) |->
		(pin_o == '0 && pin_oe_o == '0) [*3]) else $error("pins not idle");
	AST_RST_OE: assert property ($rose(rst_b_i) |->
		!serial_data_output_oe_o [*3]) else $error("serial out driven");
	AST_PIN_ON_FALL: assert property ($changed(pin_o) |-> s_low)
		else $error("pin data moved off a bus fall");
	AST_DIR_ON_FALL: assert property ($changed(pin_oe_o) |-> s_low)
		else $error("direction moved off a bus fall");
	AST_WORD2_LOW: assert property ($rose(serial_data_output_oe_o) &&
		!ser_clk_i |-> s_word2) else $error("word two not low");
	AST_OE_HOLD: assert property ($rose(serial_data_output_oe_o) |=>
		serial_data_output_oe_o [*8]) else $error("enable too short");
	AST_OE_DROP: assert property ($fell(serial_data_output_oe_o) |-> s_low)
		else $error("enable fell off a bus fall");
	AST_READ_ON_RISE: assert property ($changed(serial_data_output_o) &&
		serial_data_output_oe_o && $past(serial_data_output_oe_o) |->
		$past(ser_clk_i)) else $error("read bit moved off a rise");
endmodule
bind ger_regs ger_regs_chk u_chk (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
	.ser_clk_i(ser_clk_i), .serial_data_output_o(serial_data_output_o),
	.serial_data_output_oe_o(serial_data_output_oe_o), .pin_o(pin_o),
	.pin_oe_o(pin_oe_o));
`default_nettype wire

// ---- verif/ger_host.sv ----
/* Serial bus controller model: 48-bit frames, read word shifted in.
 * Assumes the bench calls xfer for one frame at a time. */
`default_nettype none
module ger_host (
	input  wire logic        sys_clk_i,
	input  wire logic        sdo_i,
	input  wire logic        sdo_oe_i,
	output var  logic        ser_clk_o,
	output var  logic        ser_sync_o,
	output var  logic        ser_din_o,
	output var  logic        done_o,
	output var  logic [15:0] rdat_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ser_clk_o = 1'b0;
		ser_sync_o = 1'b0;
		ser_din_o = 1'b0;
		done_o = 1'b0;
		rdat_o = 16'h0000;
	end
	task automatic xfer(input logic wr, input logic [3:0] a,
		input logic [15:0] wd);
		logic [47:0] fr;
		fr = {wr, a, 11'h000, wd, 16'h0000};
		for (int i = 0; i < 48; i++) begin
			@(posedge sys_clk_i);
			ser_clk_o  <= 1'b1;
			ser_sync_o <= (i == 0);
			ser_din_o  <= fr[47-i];
			repeat (6) @(posedge sys_clk_i);
			ser_clk_o <= 1'b0;
			if (i > 31)
				rdat_o <= {rdat_o[14:0], sdo_oe_i ? sdo_i : 1'bx};
			repeat (5) @(posedge sys_clk_i);
		end
		@(posedge sys_clk_i);
		done_o <= !wr;
		@(posedge sys_clk_i);
		done_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- verif/gpio_edge_interrupt_regs_test.sv ----
/* Self-checking bench for the pin and edge-event register block.
 * Assumes ger_host as bus controller and the bound port checker. */
`default_nettype none
module gpio_edge_interrupt_regs_test import ger_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic                sys_clk_i = 1'b0;
	logic                rst_b_i = 1'b0;
	logic                sck, sync, din, sdo, sdo_oe, done;
	logic [15:0]         ext = 16'h0000;
	logic [15:0]         rdat, d, m, r, f, o, n, e;
	logic [NUM_PINS-1:0] pin_o, pin_oe;
	wire  logic [NUM_PINS-1:0] pin_lvl;
	logic [15:0]         expq[$];
	int                  bad_count = 0;
	int                  check_count = 0;
	int                  cyc = 0;
	assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & ext[9:0]);
	always #2 sys_clk_i = ~sys_clk_i;
	ger_regs DUT (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
		.ser_clk_i(sck), .ser_sync_i(sync), .ser_din_i(din),
		.serial_data_output_o(sdo), .serial_data_output_oe_o(sdo_oe),
		.pin_i(pin_lvl), .pin_o(pin_o), .pin_oe_o(pin_oe),
		.conv_ready_i(ext[11]), .touch_plus_x_line_i(ext[12]),
		.touch_minus_x_line_i(ext[13]), .tel_clip_i(ext[14]),
		.aud_clip_i(ext[15]));
	ger_host u_host (.sys_clk_i(sys_clk_i), .sdo_i(sdo), .sdo_oe_i(sdo_oe),
		.ser_clk_o(sck), .ser_sync_o(sync), .ser_din_o(din),
		.done_o(done), .rdat_o(rdat));
	task automatic compare(input logic [15:0] g, input logic [15:0] x);
		check_count++;
		if (g !== x) begin
			bad_count++;
			$display("[FAIL] %0t read %h expected %h", $time, g, x);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		u_host.xfer(1'b1, a, v);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] x);
		expq.push_back(x);
		u_host.xfer(1'b0, a, 16'h0000);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge sys_clk_i) begin
		cyc++;
		if (done === 1'b1)
			compare(rdat, expq.pop_front());
		if (cyc == 60000) begin
			bad_count++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(32'h0D3B));
		repeat (5) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		for (int a = 0; a < 8; a++)
			rd(4'(a), RST_REG);
		$display("reset test done");
		d = 16'($urandom);
		wr(OFS_PIN_LEVEL, d);
		for (int i = 0; i < 3; i++) begin
			m = (i == 0) ? 16'hFFFF : 16'($urandom);
			ext <= 16'($urandom);
			wr(OFS_PIN_DIR, m);
			rd(OFS_PIN_DIR, m & DIR_MASK);
			e = {6'h00, (m[9:0] & d[9:0]) | (~m[9:0] & ext[9:0])};
			rd(OFS_PIN_LEVEL, e);
		end
		wr(OFS_PIN_DIR, 16'h0000);
		$display("pin test done");
		for (int i = 0; i < 6; i++) begin
			r = 16'($urandom);
			f = 16'($urandom);
			o = ext;
			wr(OFS_RISE_EN, r);
			wr(OFS_FALL_EN, f);
			wr(OFS_FLAG_CS, 16'h0000);
			wr(OFS_FLAG_CS, 16'hFFFF);
			n = 16'($urandom);
			ext <= n;
			e = ((~o & n & r) | (o & ~n & f)) & EVENT_MASK;
			rd(OFS_FALL_EN, f & EVENT_MASK);
			rd(OFS_FLAG_CS, e);
			wr(OFS_FLAG_CS, 16'hFFFF);
			rd(OFS_FLAG_CS, e);
		end
		wr(OFS_FLAG_CS, 16'h0000);
		wr(OFS_FLAG_CS, 16'hFFFF);
		rd(OFS_FLAG_CS, 16'h0000);
		$display("edge event test done");
		print_verdict();
	end
endmodule
`default_nettype wire
